// ==== rtl/adc_seq_cfg.svh ====
// Offsets, field positions, reset values and fixed codes of the step-fifteen and scratch registers
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_STEP_FIFTEEN 8'h9f
`define IDX_SCRATCH_A 8'ha0
`define IDX_SCRATCH_B 8'ha1

// ==========================================================================
// Step-fifteen field positions
`define STEP_EN_BIT 15
`define STEP_GAIN_HI 14
`define STEP_GAIN_LO 13
`define STEP_NEG_BIT 4
`define STEP_POS_HI 3
`define STEP_POS_LO 0

// ==========================================================================
// Scratch A field positions
`define SCR_A_RSV_HI_HI 15
`define SCR_A_RSV_HI_LO 12
`define SCR_A_SPARE_HI_HI 11
`define SCR_A_SPARE_HI_LO 10
`define SCR_A_RSV_MID_HI 9
`define SCR_A_RSV_MID_LO 6
`define SCR_A_SPARE_LO_HI 5
`define SCR_A_SPARE_LO_LO 4
`define SCR_A_RSV_LO_HI 3
`define SCR_A_RSV_LO_LO 0

// ==========================================================================
// Reset and fixed values
`define RST_STEP_FIFTEEN 16'h000f
`define RST_SCRATCH_A 16'h0210
`define RST_SCRATCH_B 16'h0000
`define RSV_A_HI 4'h0
`define RSV_A_MID 4'h8
`define RSV_A_LO 4'h0
`define POS_INTERNAL_MIN 4'h8
`define GAIN_ONE 3'h1
`define GAIN_TWO 3'h2
`define GAIN_FOUR 3'h4

`endif

// ==== rtl/adc_seq_pkg.sv ====
// Types shared by the step-fifteen and scratch register bank
package adc_seq_pkg;

    // ======================================================================
    // Positive source, in code order
    typedef enum logic [3:0] {
        src_ext_zero, src_ext_one, src_ext_two, src_ext_three,
        src_ext_four, src_ext_five, src_ext_six, src_ext_seven,
        src_temp_sensor, src_ground_short, src_test_dac_b, src_analog_supply_div4,
        src_io_supply_div2, src_digital_core_supply_div2, src_analog_power_div103, src_digital_power_div103
    } pos_source_e;

    typedef enum logic [1:0] {
        neg_analog_ground_ref,
        neg_external_input_seven,
        neg_automatic
    } neg_source_e;

    typedef enum logic {
        phase_wait,
        phase_answer
    } apb_phase_e;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic step_fifteen_enable;
        logic [1:0] step_fifteen_gain_code;
        logic step_fifteen_negative_select;
        logic [3:0] step_fifteen_positive_select;
    } step_cfg_s;

    typedef struct packed {
        logic [2:0] gain;
        pos_source_e pos;
        neg_source_e neg;
    } route_s;

endpackage

// ==== rtl/adc_step15_regs.sv ====
// APB register bank for sequencer step fifteen and the two scratch registers
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"

// How it works
// - Step fifteen runs only while enable bit 15 is one; reset zero.
// - Gain bits 14:13 give gain 1, 2, 4, 4; reset 00.
// - Bit 4 picks ground reference or input seven as negative input.
// - Positive codes 0 to 7 route external inputs 0 to 7.
// - Codes 8, 9, 14, 15 pick temperature, short, power dividers; reset 1111.
// - Codes 10 to 13 pick test DAC and supply dividers.
// - Internal positive sources override the negative select bit.
// - Scratch A resets to 0210h, spares 00 and 01.
// - Spare fields are plain read/write storage driving nothing.
// - Scratch A reserved fields ignore writes, read 0000, 1000, 0000.
// - Scratch B exists and resets to 0000h.
// - Step register sits at index 9Fh and resets to 000Fh.
// - All sixteen scratch B bits are read/write spares.
module adc_step15_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic step_fifteen_enable,
    output logic [2:0] step_fifteen_gain,
    output var adc_seq_pkg::pos_source_e step_fifteen_positive_route,
    output var adc_seq_pkg::neg_source_e step_fifteen_negative_route
);

    // ======================================================================
    // State
    typedef struct packed {
        adc_seq_pkg::apb_phase_e phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        adc_seq_pkg::step_cfg_s cfg;
        logic [1:0] spare_hi;
        logic [1:0] spare_lo;
        logic [15:0] scratch_b;
        logic out_enable;
        adc_seq_pkg::route_s out_route;
    } state_s;

    localparam logic [ADDR_W-1:0] ADDR_STEP = ADDR_W'({`IDX_STEP_FIFTEEN, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_A = ADDR_W'({`IDX_SCRATCH_A, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_B = ADDR_W'({`IDX_SCRATCH_B, 2'b00});
    localparam logic [15:0] STEP_RST = `RST_STEP_FIFTEEN;
    localparam logic [15:0] A_RST = `RST_SCRATCH_A;
    localparam logic [15:0] B_RST = `RST_SCRATCH_B;

    state_s st;
    state_s next_st;
    adc_seq_pkg::apb_req_s req;
    adc_seq_pkg::route_s route;
    logic [31:0] rdata;
    logic hit_step;
    logic hit_a;
    logic hit_b;
    logic done;

    assign req.psel = psel;
    assign req.penable = penable;
    assign req.pwrite = pwrite;
    assign req.paddr = 12'(paddr);
    assign req.pwdata = pwdata;

    assign hit_step = (paddr == ADDR_STEP);
    assign hit_a = (paddr == ADDR_A);
    assign hit_b = (paddr == ADDR_B);
    assign done = req.psel && req.penable && st.pready;

    // ======================================================================
    // Decode and readback
    step_route_decode u_decode (
        .cfg(st.cfg),
        .route(route)
    );

    reg_readback u_readback (
        .hit_step(hit_step),
        .hit_a(hit_a),
        .hit_b(hit_b),
        .cfg(st.cfg),
        .spare_hi(st.spare_hi),
        .spare_lo(st.spare_lo),
        .scratch_b(st.scratch_b),
        .rdata(rdata)
    );

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        // Routing outputs follow the stored fields one edge later
        next_st.out_enable = st.cfg.step_fifteen_enable;
        next_st.out_route = route;
        unique case (st.phase)
            adc_seq_pkg::phase_wait: begin
                if (req.psel && req.penable) begin
                    // One wait state so the answer leaves a flop
                    next_st.phase = adc_seq_pkg::phase_answer;
                    next_st.pready = 1'b1;
                    next_st.pslverr = !(hit_step || hit_a || hit_b);
                    next_st.prdata = req.pwrite ? 32'h0000_0000 : rdata;
                end
            end
            adc_seq_pkg::phase_answer: begin
                next_st.phase = adc_seq_pkg::phase_wait;
                next_st.pslverr = 1'b0;
                next_st.prdata = 32'h0000_0000;
            end
        endcase
        // Writes take effect only at the completing edge
        if (done && req.pwrite) begin
            if (hit_step) begin
                next_st.cfg.step_fifteen_enable = req.pwdata[`STEP_EN_BIT];
                next_st.cfg.step_fifteen_gain_code = req.pwdata[`STEP_GAIN_HI:`STEP_GAIN_LO];
                next_st.cfg.step_fifteen_negative_select = req.pwdata[`STEP_NEG_BIT];
                next_st.cfg.step_fifteen_positive_select = req.pwdata[`STEP_POS_HI:`STEP_POS_LO];
            end
            if (hit_a) begin
                next_st.spare_hi = req.pwdata[`SCR_A_SPARE_HI_HI:`SCR_A_SPARE_HI_LO];
                next_st.spare_lo = req.pwdata[`SCR_A_SPARE_LO_HI:`SCR_A_SPARE_LO_LO];
            end
            if (hit_b) begin
                next_st.scratch_b = req.pwdata[15:0];
            end
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st.phase <= adc_seq_pkg::phase_wait;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata <= 32'h0000_0000;
            st.cfg.step_fifteen_enable <= STEP_RST[`STEP_EN_BIT];
            st.cfg.step_fifteen_gain_code <= STEP_RST[`STEP_GAIN_HI:`STEP_GAIN_LO];
            st.cfg.step_fifteen_negative_select <= STEP_RST[`STEP_NEG_BIT];
            st.cfg.step_fifteen_positive_select <= STEP_RST[`STEP_POS_HI:`STEP_POS_LO];
            st.spare_hi <= A_RST[`SCR_A_SPARE_HI_HI:`SCR_A_SPARE_HI_LO];
            st.spare_lo <= A_RST[`SCR_A_SPARE_LO_HI:`SCR_A_SPARE_LO_LO];
            st.scratch_b <= B_RST;
            st.out_enable <= 1'b0;
            st.out_route.gain <= `GAIN_ONE;
            st.out_route.pos <= adc_seq_pkg::src_digital_power_div103;
            st.out_route.neg <= adc_seq_pkg::neg_automatic;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign step_fifteen_enable = st.out_enable;
    assign step_fifteen_gain = st.out_route.gain;
    assign step_fifteen_positive_route = st.out_route.pos;
    assign step_fifteen_negative_route = st.out_route.neg;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_access;
        psel && penable && !pready;
    endsequence

    sequence s_write_done(logic hit);
        psel && penable && pready && pwrite && hit;
    endsequence

    sequence s_read_done(logic hit);
        psel && penable && pready && !pwrite && hit;
    endsequence

    // ======================================================================
    // Bus handshake
    a_pready_pulse: assert property (s_access |=> pready ##1 !pready)
        else $error("pready did not pulse for one cycle");

    a_pready_single: assert property (pready |=> !pready)
        else $error("pready stood for more than one cycle");

    a_pready_needs_access: assert property (!(psel && penable) |=> !pready)
        else $error("pready rose without an access phase");

    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("answer fields shown outside the answer cycle");

    a_write_answer_zero: assert property (psel && penable && pready && pwrite |->
        prdata == 32'h0)
        else $error("write answered with read data");

    a_unmapped_error: assert property (
        psel && penable && !pready && !(hit_step || hit_a || hit_b) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    a_mapped_no_error: assert property (
        psel && penable && !pready && (hit_step || hit_a || hit_b) |=> !pslverr)
        else $error("mapped access answered with an error");

    // Refused writes must leave every stored bit alone
    a_unmapped_no_write: assert property (
        psel && penable && pready && pwrite && !(hit_step || hit_a || hit_b) |=>
        $stable(st.cfg) && $stable(st.spare_hi) && $stable(st.spare_lo) && $stable(st.scratch_b))
        else $error("unmapped write changed a register");

    // ======================================================================
    // Step fifteen fields and routing
    a_step_reset: assert property ($rose(rst_b) |-> st.cfg == 8'h0f)
        else $error("step register reset wrong");

    a_step_store: assert property (s_write_done(hit_step) |=>
        st.cfg == {$past(pwdata[15:13]), $past(pwdata[4:0])})
        else $error("step register write not stored");

    a_step_hold: assert property (!(psel && penable && pready && pwrite && hit_step) |=> $stable(st.cfg))
        else $error("step register changed without a write");

    // Route outputs lag the stored fields by one edge
    a_enable_after_write: assert property (s_write_done(hit_step) |-> ##2
        step_fifteen_enable == $past(pwdata[`STEP_EN_BIT], 2))
        else $error("step enable output did not follow write");

    a_enable_follow: assert property (1'b1 |=>
        step_fifteen_enable == $past(st.cfg.step_fifteen_enable))
        else $error("step enable output does not track the register");

    a_gain_mapping: assert property (##1 step_fifteen_gain ==
        ($past(st.cfg.step_fifteen_gain_code) == 2'b00 ? 3'h1 :
        ($past(st.cfg.step_fifteen_gain_code) == 2'b01 ? 3'h2 : 3'h4)))
        else $error("gain code decoded wrongly");

    a_gain_legal: assert property (
        step_fifteen_gain == 3'h1 || step_fifteen_gain == 3'h2 || step_fifteen_gain == 3'h4)
        else $error("gain output holds an illegal value");

    a_neg_select: assert property (st.cfg.step_fifteen_positive_select < 4'h8 |=>
        step_fifteen_negative_route == ($past(st.cfg.step_fifteen_negative_select) ?
        adc_seq_pkg::neg_external_input_seven : adc_seq_pkg::neg_analog_ground_ref))
        else $error("negative input select wrong");

    a_pos_external: assert property (st.cfg.step_fifteen_positive_select < 4'h8 |=>
        4'(step_fifteen_positive_route) == $past(st.cfg.step_fifteen_positive_select))
        else $error("external positive route wrong");

    a_pos_temp: assert property (st.cfg.step_fifteen_positive_select == 4'h8 |=>
        step_fifteen_positive_route == adc_seq_pkg::src_temp_sensor)
        else $error("temperature sensor route wrong");

    a_pos_short: assert property (st.cfg.step_fifteen_positive_select == 4'h9 |=>
        step_fifteen_positive_route == adc_seq_pkg::src_ground_short)
        else $error("ground short route wrong");

    a_pos_supply: assert property (st.cfg.step_fifteen_positive_select == 4'he |=>
        step_fifteen_positive_route == adc_seq_pkg::src_analog_power_div103)
        else $error("analog power divider route wrong");

    a_pos_digital_power: assert property (st.cfg.step_fifteen_positive_select == 4'hf |=>
        step_fifteen_positive_route == adc_seq_pkg::src_digital_power_div103)
        else $error("digital power divider route wrong");

    a_pos_test_dac: assert property (st.cfg.step_fifteen_positive_select == 4'ha |=>
        step_fifteen_positive_route == adc_seq_pkg::src_test_dac_b)
        else $error("test DAC route wrong");

    a_pos_analog_quarter: assert property (st.cfg.step_fifteen_positive_select == 4'hb |=>
        step_fifteen_positive_route == adc_seq_pkg::src_analog_supply_div4)
        else $error("analog supply quarter route wrong");

    a_pos_io_half: assert property (st.cfg.step_fifteen_positive_select == 4'hc |=>
        step_fifteen_positive_route == adc_seq_pkg::src_io_supply_div2)
        else $error("io supply half route wrong");

    a_pos_core_half: assert property (st.cfg.step_fifteen_positive_select == 4'hd |=>
        step_fifteen_positive_route == adc_seq_pkg::src_digital_core_supply_div2)
        else $error("core supply half route wrong");

    a_neg_override: assert property (st.cfg.step_fifteen_positive_select >= 4'h8 |=>
        step_fifteen_negative_route == adc_seq_pkg::neg_automatic)
        else $error("internal source did not override negative select");

    a_step_zero_bits: assert property (s_read_done(hit_step) |->
        prdata[31:16] == 16'h0 && prdata[12:5] == 8'h0)
        else $error("step register reserved bits not zero");

    a_step_readback: assert property (s_read_done(hit_step) |->
        prdata[15:13] == $past(st.cfg[7:5]) && prdata[4:0] == $past(st.cfg[4:0]))
        else $error("step register read back wrong");

    // ======================================================================
    // Scratch registers; the spares drive nothing, so only storage is checked
    a_spare_reset: assert property ($rose(rst_b) |-> st.spare_hi == 2'b00 && st.spare_lo == 2'b01)
        else $error("scratch A spares reset wrong");

    a_spare_store: assert property (s_write_done(hit_a) |=>
        st.spare_hi == $past(pwdata[11:10]) && st.spare_lo == $past(pwdata[5:4]))
        else $error("scratch A spares not stored");

    a_spare_readback: assert property (s_read_done(hit_a) |->
        prdata[11:10] == $past(st.spare_hi) && prdata[5:4] == $past(st.spare_lo))
        else $error("scratch A spares read back wrong");

    a_spare_hold: assert property (!(psel && penable && pready && pwrite && hit_a) |=>
        $stable(st.spare_hi) && $stable(st.spare_lo))
        else $error("scratch A spares changed without a write");

    a_reserved_fixed: assert property (s_read_done(hit_a) |->
        prdata[31:12] == 20'h0 && prdata[9:6] == 4'h8 && prdata[3:0] == 4'h0)
        else $error("scratch A reserved fields wrong");

    a_scratch_b_reset: assert property ($rose(rst_b) |-> st.scratch_b == 16'h0000)
        else $error("scratch B reset wrong");

    a_scratch_b_write: assert property (s_write_done(hit_b) |=> st.scratch_b == $past(pwdata[15:0]))
        else $error("scratch B not stored");

    a_scratch_b_read: assert property (s_read_done(hit_b) |->
        prdata == {16'h0000, $past(st.scratch_b)})
        else $error("scratch B read back wrong");

    a_scratch_b_hold: assert property (!(psel && penable && pready && pwrite && hit_b) |=>
        $stable(st.scratch_b))
        else $error("scratch B changed without a write");

endmodule
`default_nettype wire

// ==== rtl/reg_readback.sv ====
// Builds the read word for the addressed register
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"

module reg_readback (
    input wire logic hit_step,
    input wire logic hit_a,
    input wire logic hit_b,
    input wire adc_seq_pkg::step_cfg_s cfg,
    input wire logic [1:0] spare_hi,
    input wire logic [1:0] spare_lo,
    input wire logic [15:0] scratch_b,
    output logic [31:0] rdata
);

    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_step) begin
            // Bits 12:5 stay zero
            rdata[`STEP_EN_BIT] = cfg.step_fifteen_enable;
            rdata[`STEP_GAIN_HI:`STEP_GAIN_LO] = cfg.step_fifteen_gain_code;
            rdata[`STEP_NEG_BIT] = cfg.step_fifteen_negative_select;
            rdata[`STEP_POS_HI:`STEP_POS_LO] = cfg.step_fifteen_positive_select;
        end else if (hit_a) begin
            rdata[`SCR_A_RSV_HI_HI:`SCR_A_RSV_HI_LO] = `RSV_A_HI;
            rdata[`SCR_A_SPARE_HI_HI:`SCR_A_SPARE_HI_LO] = spare_hi;
            rdata[`SCR_A_RSV_MID_HI:`SCR_A_RSV_MID_LO] = `RSV_A_MID;
            rdata[`SCR_A_SPARE_LO_HI:`SCR_A_SPARE_LO_LO] = spare_lo;
            rdata[`SCR_A_RSV_LO_HI:`SCR_A_RSV_LO_LO] = `RSV_A_LO;
        end else if (hit_b) begin
            rdata[15:0] = scratch_b;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/step_route_decode.sv ====
// Decodes the step-fifteen fields into converter gain and input routing
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_cfg.svh"

module step_route_decode (
    input wire adc_seq_pkg::step_cfg_s cfg,
    output var adc_seq_pkg::route_s route
);

    always_comb begin
        route.pos = adc_seq_pkg::pos_source_e'(cfg.step_fifteen_positive_select);
        unique case (cfg.step_fifteen_gain_code)
            2'b00: route.gain = `GAIN_ONE;
            2'b01: route.gain = `GAIN_TWO;
            2'b10, 2'b11: route.gain = `GAIN_FOUR;
        endcase
        // Internal sources bring their own return path
        if (cfg.step_fifteen_positive_select >= `POS_INTERNAL_MIN) begin
            route.neg = adc_seq_pkg::neg_automatic;
        end else if (cfg.step_fifteen_negative_select) begin
            route.neg = adc_seq_pkg::neg_external_input_seven;
        end else begin
            route.neg = adc_seq_pkg::neg_analog_ground_ref;
        end
    end

endmodule
`default_nettype wire

// ==== tb/adc_step15_regs_test.sv ====
// Self-checking bench for the step-fifteen and scratch register bank
`timescale 1ns/100ps
`default_nettype none

module adc_step15_regs_test;
    // ======================================================================
    // Byte addresses: register index times four
    localparam logic [11:0] addr_step = 12'h27c;
    localparam logic [11:0] addr_a = 12'h280;
    localparam logic [11:0] addr_b = 12'h284;

    logic mclk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic step_fifteen_enable;
    logic [2:0] step_fifteen_gain;
    adc_seq_pkg::pos_source_e pos_route;
    adc_seq_pkg::neg_source_e neg_route;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] rng_state = 32'h00000038;

    adc_step15_regs #(.ADDR_W(12)) u_dut (
        .mclk(mclk),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .step_fifteen_enable(step_fifteen_enable),
        .step_fifteen_gain(step_fifteen_gain),
        .step_fifteen_positive_route(pos_route),
        .step_fifteen_negative_route(neg_route)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ======================================================================
    // Expectations
    function automatic logic [31:0] next_rand();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction

    function automatic logic [31:0] exp_step_read(logic [31:0] w);
        return {16'h0000, w[15:13], 8'h00, w[4:0]};
    endfunction

    function automatic logic [31:0] exp_a_read(logic [31:0] w);
        return {16'h0000, 4'h0, w[11:10], 4'h8, w[5:4], 4'h0};
    endfunction

    function automatic logic [2:0] exp_gain(logic [1:0] c);
        return (c == 2'h0) ? 3'h1 : ((c == 2'h1) ? 3'h2 : 3'h4);
    endfunction

    // Internal sources pick their own negative input
    function automatic logic [1:0] exp_neg(logic [4:0] f);
        return f[3] ? 2'h2 : {1'b0, f[4]};
    endfunction

    // ======================================================================
    // Compare and bus tasks
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_field(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Called just after an edge; leaves psel up so the next setup may follow at once
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          input logic [31:0] exp_rd, input logic exp_err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check_word("pready", 32'h1, {31'h0, pready});
        check_word("prdata", exp_rd, prdata);
        check_word("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
    endtask

    task automatic bus_release();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Decoded outputs lag the stored word by one edge
    task automatic check_route(input logic [31:0] w);
        bus_release();
        repeat (3) @(posedge mclk);
        check_field("enable", {3'h0, w[15]}, {3'h0, step_fifteen_enable});
        check_field("gain", {1'b0, exp_gain(w[14:13])}, {1'b0, step_fifteen_gain});
        check_field("positive route", w[3:0], pos_route);
        check_field("negative route", {2'h0, exp_neg(w[4:0])}, {2'h0, neg_route});
    endtask

    task automatic check_defaults();
        check_route(32'h0000000f);
        access(1'b0, addr_step, 32'h0, 32'h0000000f, 1'b0);
        access(1'b0, addr_a, 32'h0, 32'h00000210, 1'b0);
        access(1'b0, addr_b, 32'h0, 32'h00000000, 1'b0);
    endtask

    task automatic end_test(input string name);
        bus_release();
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge mclk);
        n_errors++;
        $display("MISMATCH watchdog expected done seen hang");
        report_and_stop();
    end

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] w;
        logic [31:0] last_step;
        logic [11:0] bad_addr [7];
        bad_addr = '{12'h27d, 12'h27e, 12'h283, 12'h278, 12'h288, 12'h000, 12'hfff};
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        check_defaults();
        end_test("reset values");
        last_step = 32'h0;
        for (int i = 0; i < 32; i++) begin
            w = next_rand();
            w[4:0] = i[4:0];
            w[14:13] = i[1:0] ^ i[3:2];
            w[15] = i[2] ^ i[4];
            access(1'b1, addr_step, w, 32'h0, 1'b0);
            access(1'b0, addr_step, 32'h0, exp_step_read(w), 1'b0);
            check_route(w);
            last_step = w;
        end
        end_test("step codes");
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 32'hffffffff : ((i == 1) ? 32'h0 : next_rand());
            access(1'b1, addr_a, w, 32'h0, 1'b0);
            access(1'b0, addr_a, 32'h0, exp_a_read(w), 1'b0);
            access(1'b1, addr_b, ~w, 32'h0, 1'b0);
            access(1'b0, addr_b, 32'h0, {16'h0000, ~w[15:0]}, 1'b0);
        end
        check_route(last_step);
        end_test("scratch");
        foreach (bad_addr[k]) begin
            access(1'b1, bad_addr[k], next_rand(), 32'h0, 1'b1);
            access(1'b0, bad_addr[k], 32'h0, 32'h0, 1'b1);
        end
        access(1'b0, addr_step, 32'h0, exp_step_read(last_step), 1'b0);
        end_test("unmapped");
        rst_b <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        check_defaults();
        end_test("second reset");
        report_and_stop();
    end
endmodule

`default_nettype wire
